// file: bench/lpm_chk.sv
// port checker of the power-mode controller
// assumes it is bound into lpm_ctrl, one clock, reset async high
`timescale 1ns/1ps
module lpm_chk #(
  parameter int unsigned UART_N    = 5,
  parameter int unsigned I2C_N     = 4,
  parameter int unsigned I2C_S2_IX = 2
) (
  // clock and reset
  input wire logic                clk_sys,
  input wire logic                reset,
  // inputs seen
  input wire logic                irq_event,
  input wire logic                reset_src_internal,
  input wire logic                io_release,
  input wire logic                vdd_present,
  input wire logic [UART_N-1:0]   uart_start,
  input wire logic [UART_N-1:0]   uart_addr,
  input wire logic [UART_N-1:0]   uart_frame,
  input wire logic [I2C_N-1:0]    i2c_addr_match,
  // outputs seen
  input wire logic                main_regulator_en,
  input wire logic                low_power_regulator_en,
  input wire logic                core_power_en,
  input wire logic [1:0]          clk_cap,
  input wire logic                pll_allowed,
  input wire logic                rng_available,
  input wire logic                io_analog,
  input wire logic                reset_pullup_en,
  input wire logic                battery_mode,
  input wire logic                wake_irq,
  input wire lpm_pkg::lpm_state_t mode_state
);
  import lpm_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  main_reg_a: assert property (
    mode_state inside {ST_RUN, ST_SLEEP, ST_STOP0} |-> main_regulator_en)
    else $error("main regulator off");
  lp_reg_a: assert property (
    mode_state inside {ST_LP_RUN, ST_LP_SLEEP, ST_STOP1, ST_STOP2}
    |-> low_power_regulator_en && !main_regulator_en) else $error("wrong regulator");
  off_modes_a: assert property (
    mode_state inside {ST_STANDBY, ST_SHUTDOWN} |-> !main_regulator_en && !core_power_en)
    else $error("core powered in standby");
  lp_run_cap_a: assert property (
    mode_state == ST_LP_RUN |-> clk_cap == CLK_CAP_2MHZ) else $error("lp run cap");
  sleep_wake_a: assert property (
    mode_state == ST_SLEEP && irq_event && vdd_present |=> wake_irq && mode_state == ST_WAKE
    ##1 (mode_state == ST_WAKE) [*6] ##1 mode_state == ST_RUN) else $error("sleep wake");
  stop2_i2c_a: assert property (
    mode_state == ST_STOP2 && vdd_present && !irq_event && !i2c_addr_match[I2C_S2_IX]
    && uart_start == '0 && uart_addr == '0 && uart_frame == '0 |=> mode_state == ST_STOP2)
    else $error("stop2 left");
  no_rng_pll_a: assert property (
    low_power_regulator_en && core_power_en |-> !rng_available && !pll_allowed)
    else $error("rng or pll on");
  pullup_a: assert property (
    !$past(reset) |-> reset_pullup_en == !$past(reset_src_internal)) else $error("pull-up");
  analog_hold_a: assert property (
    $fell(io_analog) |-> $past(io_release)) else $error("analog state left");
  vbat_hold_a: assert property (
    mode_state == ST_VBAT && !vdd_present |=> mode_state == ST_VBAT && battery_mode)
    else $error("battery mode left");
endmodule

bind lpm_ctrl lpm_chk #(.UART_N(UART_N), .I2C_N(I2C_N), .I2C_S2_IX(I2C_S2_IX)) u_chk (
  .clk_sys, .reset, .irq_event, .reset_src_internal, .io_release, .vdd_present,
  .uart_start, .uart_addr, .uart_frame, .i2c_addr_match, .main_regulator_en,
  .low_power_regulator_en, .core_power_en, .clk_cap, .pll_allowed, .rng_available,
  .io_analog, .reset_pullup_en, .battery_mode, .wake_irq, .mode_state);

// file: bench/lpm_ctrl_bench.sv
// scenario bench of the power-mode controller
// assumes 20 MHz clk_sys; all inputs change on the falling edge
`timescale 1ns/1ps
module lpm_ctrl_bench;
  import lpm_pkg::*;
  logic        clk_sys, reset, wait_req, range2_sel, lp_run_req, lp_run_exit_req, go;
  logic        second_sram_retention_select, flash_pd_cfg, exec_from_sram, io_release;
  logic        reset_src_internal, irq_event, vdd_present, main_regulator_en, hsi_en;
  logic        low_power_regulator_en, regulator_hiz, core_power_en, cpu_clk_en;
  logic        pll_allowed, rng_available, low_speed_only, periph_freeze, flash_on;
  logic        second_sram_power, io_analog, io_pull_apply, reset_pullup_en, battery_mode, wake_irq;
  logic [1:0]  clk_cap;
  logic [2:0]  kind, idx;
  logic [4:0]  uart_start, uart_addr, uart_frame, wake_pin;
  logic [3:0]  i2c_addr_match;
  logic [7:0]  hsi_req, hsi_grant;
  logic [31:0] io_pull_sel, io_pull;
  lpm_target_t target_sel;
  lpm_state_t  mode_state;
  int          failures, samples_checked;

  lpm_ctrl DUT (
    .clk_sys, .reset, .wait_req, .target_sel, .range2_sel, .lp_run_req, .lp_run_exit_req,
    .second_sram_retention_select, .flash_pd_cfg, .exec_from_sram, .io_release, .io_pull_sel,
    .reset_src_internal, .irq_event, .uart_start, .uart_addr, .uart_frame, .i2c_addr_match,
    .wake_pin, .hsi_req, .vdd_present, .main_regulator_en, .low_power_regulator_en,
    .regulator_hiz, .core_power_en, .cpu_clk_en, .clk_cap, .pll_allowed, .rng_available,
    .hsi_en, .hsi_grant, .low_speed_only, .periph_freeze, .flash_on, .second_sram_power,
    .io_analog, .io_pull_apply, .io_pull, .reset_pullup_en, .battery_mode, .wake_irq,
    .mode_state);
  lpm_far far (.go, .kind, .idx, .wait_req, .irq_event, .uart_start, .uart_addr,
    .uart_frame, .i2c_addr_match, .wake_pin, .hsi_req);

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic fire(input logic [2:0] k, input logic [2:0] i, input int hold);
    @(negedge clk_sys);
    kind = k;
    idx = i;
    go = 1'h1;
    repeat (hold) @(negedge clk_sys);
    go = 1'h0;
  endtask
  // bounded wait for run; a hang ends the run as a mismatch
  task automatic to_run(input int lim, output int n);
    n = 0;
    while (mode_state !== ST_RUN && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    if (mode_state !== ST_RUN) begin
      failures++;
      wrap_up();
    end
  endtask
  task automatic enter(input lpm_target_t t);
    target_sel = t;
    fire(3'h0, 3'h0, 1);
  endtask

  task automatic t_run();
    repeat (3) @(negedge clk_sys);
    chk(io_analog, 1'h1);
    {reset_src_internal, range2_sel, flash_pd_cfg} = 3'h7;
    repeat (2) @(negedge clk_sys);
    chk(reset_pullup_en, 1'h0);
    chk(clk_cap, CLK_CAP_26MHZ);
    chk(rng_available, 1'h0);
    chk(flash_on, 1'h0);
    {reset_src_internal, range2_sel, flash_pd_cfg, io_release} = 4'h1;
    repeat (2) @(negedge clk_sys);
    io_release = 1'h0;
    chk(reset_pullup_en, 1'h1);
    chk(clk_cap, CLK_CAP_80MHZ);
    chk({pll_allowed, rng_available}, 2'h3);
    chk(io_analog, 1'h0);
  endtask
  task automatic t_sleep();
    int n;
    enter(TGT_SLEEP);
    chk({mode_state, cpu_clk_en, main_regulator_en}, {ST_SLEEP, 2'h1});
    fire(3'h1, 3'h0, 1);
    chk(wake_irq, 1'h1);
    to_run(20, n);
    chk(n, SLEEP_WAKE_CYC + 1);
  endtask
  task automatic t_lp_run_mode(input logic r2, input int exp);
    int n;
    range2_sel = r2;
    lp_run_req = 1'h1;
    @(negedge clk_sys);
    lp_run_req = 1'h0;
    chk(mode_state, ST_LP_RUN);
    chk({main_regulator_en, low_power_regulator_en}, 2'h1);
    chk({pll_allowed, rng_available}, 2'h0);
    enter(TGT_SLEEP);
    fire(3'h1, 3'h0, 1);
    chk(wake_irq, 1'h1);
    repeat (7) @(negedge clk_sys);
    lp_run_exit_req = 1'h1;
    @(negedge clk_sys);
    lp_run_exit_req = 1'h0;
    to_run(1400, n);
    chk(n, exp);
    range2_sel = 1'h0;
  endtask
  task automatic t_stop(input lpm_target_t t, input lpm_state_t st, input logic [2:0] k,
                        input logic [2:0] i, input logic sram);
    int n;
    exec_from_sram = sram;
    enter(t);
    chk(mode_state, st);
    if (st == ST_STOP0) begin
      chk({main_regulator_en, flash_on, periph_freeze, low_speed_only}, 4'hB);
    end
    fire(k, i, 1);
    to_run(100, n);
    chk(n, (sram ? 2470 : 4100) / 50 + 1 + (sram ? 1 : 0));
  endtask
  task automatic t_stop2();
    int n;
    enter(TGT_STOP2);
    for (int i = 0; i < 4; i++) begin
      if (i != 2) fire(3'h5, i[2:0], 1);
    end
    chk(mode_state, ST_STOP2);
    fire(3'h5, 3'h2, 1);
    chk(wake_irq, 1'h1);
    to_run(100, n);
  endtask
  task automatic t_standby(input int p);
    int n;
    lpm_target_t t;
    t = (p == 4) ? TGT_SHUTDOWN : TGT_STANDBY;
    second_sram_retention_select = p[0];
    io_pull_sel = 32'h1296_A458 << (2 * p);
    enter(t);
    chk({core_power_en, main_regulator_en}, 2'h0);
    chk(regulator_hiz, !p[0]);
    chk({second_sram_power, low_power_regulator_en}, {2{p[0]}});
    chk(io_pull_apply, 1'h1);
    chk(io_pull, io_pull_sel);
    fire(3'h6, p[2:0], 4);
    to_run(150, n);
    chk(io_pull, (t == TGT_SHUTDOWN) ? 32'h0000_0000 : io_pull_sel);
  endtask
  task automatic t_hsi();
    kind = 3'h7;
    idx = 3'h5;
    go = 1'h1;
    repeat (3) @(negedge clk_sys);
    chk({hsi_en, hsi_grant}, 9'h120);
    go = 1'h0;
    repeat (3) @(negedge clk_sys);
    chk({hsi_en, hsi_grant}, 9'h000);
  endtask
  task automatic t_vbat();
    int n;
    int k;
    vdd_present = 1'h0;
    k = 0;
    while (mode_state !== ST_VBAT && k < 8) begin
      @(negedge clk_sys);
      k++;
    end
    chk({battery_mode, k[3:0]}, 5'h13);
    fire(3'h1, 3'h0, 1);
    fire(3'h6, 3'h1, 4);
    fire(3'h2, 3'h0, 1);
    chk(mode_state, ST_VBAT);
    vdd_present = 1'h1;
    to_run(150, n);
  endtask

  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    {range2_sel, lp_run_req, lp_run_exit_req, second_sram_retention_select, flash_pd_cfg} = '0;
    {exec_from_sram, io_release, reset_src_internal, go, kind, idx} = '0;
    {reset, vdd_present} = 2'h3;
    target_sel = TGT_SLEEP;
    io_pull_sel = '0;
    failures = 0;
    samples_checked = 0;
    repeat (4) @(negedge clk_sys);
    chk({io_analog, flash_on, main_regulator_en}, {RST_IO_ANALOG, !RST_FLASH_PD, 1'h1});
    chk(mode_state, ST_RUN);
    reset = 1'h0;
    t_run();
    t_sleep();
    t_lp_run_mode(1'h0, 4000 / 50 + 1);
    t_lp_run_mode(1'h1, 64000 / 50 + 1);
    t_stop(TGT_STOP0, ST_STOP0, 3'h2, 3'h4, 1'h1);
    t_stop(TGT_STOP0, ST_STOP0, 3'h3, 3'h0, 1'h0);
    t_stop(TGT_STOP1, ST_STOP1, 3'h4, 3'h1, 1'h1);
    t_stop(TGT_STOP1, ST_STOP1, 3'h5, 3'h3, 1'h1);
    t_stop2();
    for (int p = 0; p < 5; p++) t_standby(p);
    t_hsi();
    t_vbat();
    wrap_up();
  end
endmodule

// file: bench/lpm_far.sv
// far side: core wait request, peripheral wakeup events, wake pins
// assumes go, kind and idx change on the falling edge of clk_sys
`timescale 1ns/1ps
module lpm_far #(
  parameter int unsigned UART_N = 5,
  parameter int unsigned I2C_N  = 4,
  parameter int unsigned HSI_N  = 8
) (
  // command
  input wire logic                      go,
  input wire logic [2:0]                kind,
  input wire logic [2:0]                idx,
  // core and peripheral lines
  output logic                          wait_req,
  output logic                          irq_event,
  output logic [UART_N-1:0]             uart_start,
  output logic [UART_N-1:0]             uart_addr,
  output logic [UART_N-1:0]             uart_frame,
  output logic [I2C_N-1:0]              i2c_addr_match,
  output logic [lpm_pkg::WAKE_PIN_N-1:0] wake_pin,
  output logic [HSI_N-1:0]              hsi_req
);
  import lpm_pkg::*;
  logic [7:0] one_hot;
  always_comb begin
    one_hot = 8'h01 << idx;
    // wait only once target is set
    wait_req = go && kind == 3'h0;
    irq_event = go && kind == 3'h1;
    uart_start = (go && kind == 3'h2) ? one_hot[UART_N-1:0] : '0;
    uart_addr = (go && kind == 3'h3) ? one_hot[UART_N-1:0] : '0;
    uart_frame = (go && kind == 3'h4) ? one_hot[UART_N-1:0] : '0;
    i2c_addr_match = (go && kind == 3'h5) ? one_hot[I2C_N-1:0] : '0;
    wake_pin = (go && kind == 3'h6) ? one_hot[WAKE_PIN_N-1:0] : '0;
    // level request held as long as the peripheral needs it
    hsi_req = (go && kind == 3'h7) ? one_hot[HSI_N-1:0] : '0;
  end
endmodule

// file: verilog/lpm_ctrl.sv
// power-mode controller: regulator choice, scaling range, clock ceilings,
// wakeup with fixed latencies, retention, pull handling, battery switchover
// assumes peripheral inputs are on clk_sys; pins and supply sense are async
//
// Overview of operation
// - main regulator in run, sleep, stop0
// - low-power regulator in lp and stop1/2 modes
// - standby/shutdown: regulators off, outputs high-z, except lp regulator on in standby with sram retained
// - range1 up to 80 MHz, range2 26 MHz
// - lp run: main off, cpu 2 MHz
// - sleep modes wake on event, 6 cycles
// - lp run exit 4 us or 64 us
// - stop0 flash off, freeze, timed wakeup
// - 16 MHz oscillator only for its requesters
// - uart start/address/frame wakes from stop
// - all i2c address matches wake stop1
// - only third i2c wakes stop2
// - second sram retained only when selected
// - five pins wake standby or shutdown
// - standby applies selected i/o pulls
// - shutdown pulls lost on exit
// - i/o analog during and after reset
// - reset pin pull-up off if internal
// - battery domain when main supply absent
// - interrupts never end battery operation
// - flash powerdown configurable, off after reset
// - no rng or pll in lp regulator modes; pll still allowed in stop0
`timescale 1ns/1ps
module lpm_ctrl #(
  parameter int unsigned IO_W      = 16,
  parameter int unsigned UART_N    = 5,
  parameter int unsigned I2C_N     = 4,
  parameter int unsigned I2C_S2_IX = 2,
  parameter int unsigned HSI_N     = 8
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  // software requests and configuration
  input  wire logic                  wait_req,
  input  wire lpm_pkg::lpm_target_t  target_sel,
  input  wire logic                  range2_sel,
  input  wire logic                  lp_run_req,
  input  wire logic                  lp_run_exit_req,
  input  wire logic                  second_sram_retention_select,
  input  wire logic                  flash_pd_cfg,
  input  wire logic                  exec_from_sram,
  input  wire logic                  io_release,
  input  wire logic [2*IO_W-1:0]     io_pull_sel,
  input  wire logic                  reset_src_internal,
  // wakeup sources
  input  wire logic                  irq_event,
  input  wire logic [UART_N-1:0]     uart_start,
  input  wire logic [UART_N-1:0]     uart_addr,
  input  wire logic [UART_N-1:0]     uart_frame,
  input  wire logic [I2C_N-1:0]      i2c_addr_match,
  input  wire logic [lpm_pkg::WAKE_PIN_N-1:0] wake_pin,
  input  wire logic [HSI_N-1:0]      hsi_req,
  input  wire logic                  vdd_present,
  // supply and clock control
  output logic                       main_regulator_en,
  output logic                       low_power_regulator_en,
  output logic                       regulator_hiz,
  output logic                       core_power_en,
  output logic                       cpu_clk_en,
  output logic [1:0]                 clk_cap,
  output logic                       pll_allowed,
  output logic                       rng_available,
  output logic                       hsi_en,
  output logic [HSI_N-1:0]           hsi_grant,
  output logic                       low_speed_only,
  output logic                       periph_freeze,
  // memories and i/o
  output logic                       flash_on,
  output logic                       second_sram_power,
  output logic                       io_analog,
  output logic                       io_pull_apply,
  output logic [2*IO_W-1:0]          io_pull,
  output logic                       reset_pullup_en,
  // status
  output logic                       battery_mode,
  output logic                       wake_irq,
  output lpm_pkg::lpm_state_t        mode_state
);
  import lpm_pkg::*;

  if (I2C_S2_IX >= I2C_N || LP_RUN_MODE_EXIT_R2_CYC >= (1 << TMR_W)) begin : g_chk
    $error("lpm_ctrl: parameter out of range");
  end

  typedef struct packed {
    lpm_state_t                state;
    lpm_state_t                ret_state;
    logic                      range2;
    logic                      retain;
    logic                      leave_shut;
    logic                      main_reg;
    logic                      lp_reg;
    logic                      reg_hiz;
    logic                      core_pwr;
    logic                      cpu_clk;
    logic [1:0]                cap;
    logic                      pll_ok;
    logic                      rng_ok;
    logic                      hsi;
    logic [HSI_N-1:0]          grant;
    logic                      ls_only;
    logic                      freeze;
    logic                      flash;
    logic                      second_sram;
    logic                      analog;
    logic                      pull_apply;
    logic [2*IO_W-1:0]         pull;
    logic                      rst_pu;
    logic                      vbat;
    logic                      wake;
    logic [WAKE_PIN_N-1:0]     pin_s1;
    logic [WAKE_PIN_N-1:0]     pin_s2;
    logic [WAKE_PIN_N-1:0]     pin_s3;
    logic                      vdd_s1;
    logic                      vdd_s2;
  } lpm_st_t;

  lpm_st_t    s_q;
  lpm_st_t    s_d;
  lpm_tmr_if  tif ();

  lpm_tmr u_tmr (
    .clk_sys (clk_sys),
    .reset   (reset),
    .tif     (tif)
  );

  logic             tmr_load;
  logic [TMR_W-1:0] tmr_value;
  assign tif.load  = tmr_load;
  assign tif.value = tmr_value;

  logic uart_wake;
  logic i2c_s1_wake;
  logic i2c_s2_wake;
  logic pin_wake;
  logic stop_wake_cyc;

  assign uart_wake   = |(uart_start | uart_addr | uart_frame);
  assign i2c_s1_wake = |i2c_addr_match;
  assign i2c_s2_wake = i2c_addr_match[I2C_S2_IX];
  assign pin_wake    = |(s_q.pin_s2 & ~s_q.pin_s3);

  always_comb begin
    s_d           = s_q;
    tmr_load      = 1'b0;
    tmr_value     = TMR_W'(SLEEP_WAKE_CYC);
    stop_wake_cyc = 1'b0;
    s_d.wake      = 1'b0;
    s_d.leave_shut = 1'b0;

    // pins and supply sense are asynchronous: two flops first
    s_d.pin_s1 = wake_pin;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_s3 = s_q.pin_s2;
    s_d.vdd_s1 = vdd_present;
    s_d.vdd_s2 = s_q.vdd_s1;

    unique case (s_q.state)
      ST_RUN: begin
        s_d.range2 = range2_sel;
        if (wait_req) begin
          unique case (target_sel)
            TGT_SLEEP:    s_d.state = ST_SLEEP;
            TGT_STOP0:    s_d.state = ST_STOP0;
            TGT_STOP1:    s_d.state = ST_STOP1;
            TGT_STOP2:    s_d.state = ST_STOP2;
            TGT_STANDBY:  s_d.state = ST_STANDBY;
            TGT_SHUTDOWN: s_d.state = ST_SHUTDOWN;
          endcase
        end else if (lp_run_req) begin
          s_d.state = ST_LP_RUN;
        end
      end
      ST_LP_RUN: begin
        if (wait_req && target_sel == TGT_SLEEP) begin
          s_d.state = ST_LP_SLEEP;
        end else if (wait_req) begin
          unique case (target_sel)
            TGT_STOP0:    s_d.state = ST_STOP0;
            TGT_STOP1:    s_d.state = ST_STOP1;
            TGT_STOP2:    s_d.state = ST_STOP2;
            TGT_STANDBY:  s_d.state = ST_STANDBY;
            TGT_SHUTDOWN: s_d.state = ST_SHUTDOWN;
            default:      s_d.state = ST_LP_SLEEP;
          endcase
        end else if (lp_run_exit_req) begin
          // exit time set by target range
          s_d.range2    = range2_sel;
          s_d.ret_state = ST_RUN;
          s_d.state     = ST_WAKE;
          tmr_load      = 1'b1;
          tmr_value     = range2_sel ? TMR_W'(LP_RUN_MODE_EXIT_R2_CYC) : TMR_W'(LP_RUN_MODE_EXIT_R1_CYC);
        end
      end
      ST_SLEEP, ST_LP_SLEEP: begin
        if (irq_event) begin
          s_d.ret_state = (s_q.state == ST_SLEEP) ? ST_RUN : ST_LP_RUN;
          s_d.state     = ST_WAKE;
          s_d.wake      = 1'b1;
          tmr_load      = 1'b1;
          tmr_value     = TMR_W'(SLEEP_WAKE_CYC);
        end
      end
      ST_STOP0: begin
        stop_wake_cyc = irq_event | uart_wake | i2c_s1_wake;
      end
      ST_STOP1: begin
        stop_wake_cyc = irq_event | uart_wake | i2c_s1_wake;
      end
      ST_STOP2: begin
        stop_wake_cyc = irq_event | uart_wake | i2c_s2_wake;
      end
      ST_STANDBY, ST_SHUTDOWN: begin
        if (pin_wake) begin
          s_d.leave_shut = (s_q.state == ST_SHUTDOWN);
          s_d.ret_state  = ST_RUN;
          s_d.state      = ST_WAKE;
          s_d.wake       = 1'b1;
          tmr_load       = 1'b1;
          tmr_value      = TMR_W'(STOP0_WAKE_FLASH_CYC);
        end
      end
      ST_VBAT: begin
        // only the supply return ends it
        if (s_q.vdd_s2) begin
          s_d.ret_state = ST_RUN;
          s_d.state     = ST_WAKE;
          tmr_load      = 1'b1;
          tmr_value     = TMR_W'(STOP0_WAKE_FLASH_CYC);
        end
      end
      ST_WAKE: begin
        if (tif.done || !tif.busy) begin
          s_d.state = s_q.ret_state;
        end
      end
    endcase

    // stop wakeup latency by code location
    if (stop_wake_cyc) begin
      s_d.ret_state = ST_RUN;
      s_d.state     = ST_WAKE;
      s_d.wake      = 1'b1;
      tmr_load      = 1'b1;
      tmr_value     = exec_from_sram ? TMR_W'(STOP0_WAKE_SRAM_CYC)
                                     : TMR_W'(STOP0_WAKE_FLASH_CYC);
    end

    if (!s_q.vdd_s2) begin
      s_d.state = ST_VBAT;
      s_d.wake  = 1'b0;
      tmr_load  = 1'b0;
    end
    s_d.vbat = (s_d.state == ST_VBAT);

    // retention select latched at standby entry
    if (s_d.state == ST_STANDBY && s_q.state != ST_STANDBY) begin
      s_d.retain = second_sram_retention_select;
    end

    // pulls captured on entry, applied while low
    if ((s_d.state == ST_STANDBY || s_d.state == ST_SHUTDOWN) && s_d.state != s_q.state) begin
      s_d.pull = io_pull_sel;
    end
    s_d.pull_apply = (s_d.state == ST_STANDBY) || (s_d.state == ST_SHUTDOWN);
    if (s_d.leave_shut) begin
      s_d.pull = {IO_W{PULL_FLOAT}};
    end

    if (io_release) begin
      s_d.analog = 1'b0;
    end

    s_d.rst_pu = !reset_src_internal;

    // outputs follow the next state so each comes from a flop
    s_d.main_reg = 1'b0;
    s_d.lp_reg   = 1'b0;
    s_d.reg_hiz  = 1'b0;
    s_d.core_pwr = 1'b1;
    s_d.cpu_clk  = 1'b0;
    s_d.flash    = 1'b1;
    s_d.freeze   = 1'b0;
    s_d.ls_only  = 1'b0;
    s_d.second_sram    = 1'b1;
    s_d.cap      = CLK_CAP_STOP;
    unique case (s_d.state)
      ST_RUN, ST_SLEEP, ST_WAKE: begin
        s_d.main_reg = 1'b1;
        s_d.cap      = s_d.range2 ? CLK_CAP_26MHZ : CLK_CAP_80MHZ;
        s_d.cpu_clk  = (s_d.state == ST_RUN);
      end
      ST_LP_RUN, ST_LP_SLEEP: begin
        s_d.lp_reg  = 1'b1;
        s_d.cap     = CLK_CAP_2MHZ;
        s_d.cpu_clk = (s_d.state == ST_LP_RUN);
      end
      ST_STOP0: begin
        s_d.main_reg = 1'b1;
        s_d.flash    = 1'b0;
        s_d.ls_only  = 1'b1;
        s_d.freeze   = 1'b1;
      end
      ST_STOP1, ST_STOP2: begin
        s_d.lp_reg  = 1'b1;
        s_d.flash   = 1'b0;
        s_d.ls_only = 1'b1;
        s_d.freeze  = 1'b1;
      end
      ST_STANDBY, ST_SHUTDOWN, ST_VBAT: begin
        s_d.reg_hiz  = 1'b1;
        s_d.core_pwr = 1'b0;
        s_d.flash    = 1'b0;
        s_d.freeze   = 1'b1;
        s_d.ls_only  = 1'b1;
        // second sram kept on lp regulator
        s_d.second_sram    = (s_d.state == ST_STANDBY) && s_d.retain;
        s_d.lp_reg   = s_d.second_sram;
        s_d.reg_hiz  = !s_d.second_sram;
      end
    endcase
    if (s_d.flash && flash_pd_cfg && s_d.state != ST_WAKE) begin
      s_d.flash = 1'b0;
    end

    // rng and pll only with main regulator
    s_d.pll_ok = s_d.main_reg;
    s_d.rng_ok = s_d.main_reg && !s_d.range2 && !s_d.freeze;

    s_d.hsi   = s_d.core_pwr && (|hsi_req);
    s_d.grant = s_d.hsi ? hsi_req : '0;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_q           <= '0;
      s_q.state     <= ST_RUN;
      s_q.ret_state <= ST_RUN;
      s_q.range2    <= RST_RANGE2;
      s_q.main_reg  <= 1'b1;
      s_q.core_pwr  <= 1'b1;
      s_q.cpu_clk   <= 1'b1;
      s_q.flash     <= !RST_FLASH_PD;
      s_q.second_sram     <= 1'b1;
      s_q.pll_ok    <= 1'b1;
      s_q.rng_ok    <= 1'b1;
      s_q.cap       <= CLK_CAP_80MHZ;
      s_q.analog    <= RST_IO_ANALOG;
      s_q.rst_pu    <= 1'b1;
      s_q.vdd_s1    <= 1'b1;
      s_q.vdd_s2    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign main_regulator_en      = s_q.main_reg;
  assign low_power_regulator_en = s_q.lp_reg;
  assign regulator_hiz          = s_q.reg_hiz;
  assign core_power_en          = s_q.core_pwr;
  assign cpu_clk_en             = s_q.cpu_clk;
  assign clk_cap                = s_q.cap;
  assign pll_allowed            = s_q.pll_ok;
  assign rng_available          = s_q.rng_ok;
  assign hsi_en                 = s_q.hsi;
  assign hsi_grant              = s_q.grant;
  assign low_speed_only         = s_q.ls_only;
  assign periph_freeze          = s_q.freeze;
  assign flash_on               = s_q.flash;
  assign second_sram_power            = s_q.second_sram;
  assign io_analog              = s_q.analog;
  assign io_pull_apply          = s_q.pull_apply;
  assign io_pull                = s_q.pull;
  assign reset_pullup_en        = s_q.rst_pu;
  assign battery_mode           = s_q.vbat;
  assign wake_irq               = s_q.wake;
  assign mode_state             = s_q.state;
endmodule

// file: verilog/lpm_pkg.sv
// constants, types and timing counts of the low-power mode controller
// assumes a single 20 MHz system clock feeding every user of these names
package lpm_pkg;

  localparam int unsigned CLK_MHZ = 20;

  // wakeup latencies as printed
  localparam int unsigned SLEEP_WAKE_CYC     = 6;
  localparam int unsigned LP_RUN_MODE_EXIT_R1_NS   = 4000;
  localparam int unsigned LP_RUN_MODE_EXIT_R2_NS   = 64000;
  localparam int unsigned STOP0_WAKE_SRAM_NS = 2470;
  localparam int unsigned STOP0_WAKE_FLASH_NS = 4100;

  // least times, rounded up to whole cycles
  localparam int unsigned LP_RUN_MODE_EXIT_R1_CYC   = (LP_RUN_MODE_EXIT_R1_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned LP_RUN_MODE_EXIT_R2_CYC   = (LP_RUN_MODE_EXIT_R2_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STOP0_WAKE_SRAM_CYC = (STOP0_WAKE_SRAM_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STOP0_WAKE_FLASH_CYC = (STOP0_WAKE_FLASH_NS * CLK_MHZ + 999) / 1000;

  localparam int unsigned TMR_W = 11;

  // clock ceiling codes
  localparam logic [1:0] CLK_CAP_80MHZ = 2'h0;
  localparam logic [1:0] CLK_CAP_26MHZ = 2'h1;
  localparam logic [1:0] CLK_CAP_2MHZ  = 2'h2;
  localparam logic [1:0] CLK_CAP_STOP  = 2'h3;

  // pull codes of one I/O
  localparam logic [1:0] PULL_FLOAT = 2'h0;
  localparam logic [1:0] PULL_UP    = 2'h1;
  localparam logic [1:0] PULL_DOWN  = 2'h2;

  localparam int unsigned WAKE_PIN_N = 5;

  // reset values
  localparam logic RST_IO_ANALOG = 1'b1;
  localparam logic RST_FLASH_PD  = 1'b0;
  localparam logic RST_RANGE2    = 1'b0;

  typedef enum logic [2:0] {
    TGT_SLEEP,
    TGT_STOP0,
    TGT_STOP1,
    TGT_STOP2,
    TGT_STANDBY,
    TGT_SHUTDOWN
  } lpm_target_t;

  typedef enum logic [3:0] {
    ST_RUN,
    ST_SLEEP,
    ST_LP_RUN,
    ST_LP_SLEEP,
    ST_STOP0,
    ST_STOP1,
    ST_STOP2,
    ST_STANDBY,
    ST_SHUTDOWN,
    ST_VBAT,
    ST_WAKE
  } lpm_state_t;

endpackage

// file: verilog/lpm_tmr.sv
// down counter giving one done pulse a loaded number of cycles later
// assumes value is at least one when load is high
`timescale 1ns/1ps
module lpm_tmr (
  // clock and reset
  input  wire logic   clk_sys,
  input  wire logic   reset,
  // control side
  lpm_tmr_if.tmr      tif
);
  import lpm_pkg::*;

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic             done;
  } lpm_tmr_st_t;

  lpm_tmr_st_t s_q;
  lpm_tmr_st_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (tif.load) begin
      s_d.cnt = tif.value;
    end else if (s_q.cnt != '0) begin
      s_d.cnt  = s_q.cnt - 1'b1;
      s_d.done = (s_q.cnt == TMR_W'(1));
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tif.busy = (s_q.cnt != '0);
  assign tif.done = s_q.done;
endmodule

// file: verilog/lpm_tmr_if.sv
// carrier between the mode controller and its latency timer
// assumes both ends sit on clk_sys
`timescale 1ns/1ps
interface lpm_tmr_if;
  import lpm_pkg::*;
  logic             load;
  logic [TMR_W-1:0] value;
  logic             busy;
  logic             done;
  modport ctl (output load, output value, input busy, input done);
  modport tmr (input load, input value, output busy, output done);
endinterface
